//--- pkg/sstc_defs.vh
/*
 * Constants of the synchronous serial transmit controller:
 * register offsets, flag positions, reset values and characters.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef SSTC_DEFS_VH
`define SSTC_DEFS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SSTC_OFF_SELECT     12'h000
`define SSTC_OFF_FLAG_IN    12'h004
`define SSTC_OFF_FLAG_OUT   12'h008
`define SSTC_OFF_DATA_IN    12'h00c
`define SSTC_OFF_TRANSMIT   12'h010
`define SSTC_OFF_INIT       12'h014
`define SSTC_OFF_DEV_CLEAR  12'h018
`define SSTC_OFF_START_ADDR 12'h01c
`define SSTC_OFF_TERM_ADDR  12'h020
`define SSTC_OFF_TERM_CHAR  12'h024
`define SSTC_OFF_CUR_ADDR   12'h028
`define SSTC_OFF_IRQ_STATUS 12'h02c
`define SSTC_OFF_IRQ_MASK   12'h030
`define SSTC_BUF_PAGE       2'h1
`define SSTC_BUF_PAGE_HI    11
`define SSTC_BUF_PAGE_LO    10
`define SSTC_BUF_IDX_HI     9
`define SSTC_BUF_IDX_LO     2

// ---------------------------------------------------------------
// fields and values
// ---------------------------------------------------------------
`define SSTC_SELECT_CODE    8'hc3
`define SSTC_OPEN_BUS       8'hff
`define SSTC_SYN_CHAR       8'h16
`define SSTC_MARK_CHAR      8'hff
`define SSTC_ZERO_BYTE      8'h00
`define SSTC_FLAG_NOT_BUSY  7
`define SSTC_FLAG_DSR       1
`define SSTC_OUT_DTR        4
`define SSTC_IRQ_DONE       0
`define SSTC_IRQ_DSR        1
`define SSTC_IRQ_W          2
`define SSTC_BIT_LAST       3'h7
`define SSTC_BIT_FIRST      3'h0

`endif

//--- rtl/sstc_controller.v
/*
 * Synchronous serial transmit controller with APB register access,
 * host select decode, modem flags and buffer transmit sequencer.
 * Assumes an APB master on clock_i and an external modem supplying
 * tx_clk_i, cts_i and dsr_i, all asynchronous to clock_i.
 */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "sstc_defs.vh"

module sstc_controller (
   input  wire        clock_i,
   input  wire        rst_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output wire        pready_o,
   output reg  [31:0] prdata_o,
   output reg         pslverr_o,
   input  wire        tx_clk_i,
   input  wire        cts_i,
   input  wire        dsr_i,
   output reg         txd_o,
   output reg         rts_o,
   output reg         dtr_o,
   output wire        irq_level6_o,
   output wire        irq_o
);

   // ------------------------------------------------------------
   // storage and state
   // ------------------------------------------------------------
   reg  [7:0]  buffer_mem [0:255];
   reg         ready;
   reg         selected;
   reg         not_busy;
   reg         active;
   reg         first;
   reg  [7:0]  start_addr;
   reg  [7:0]  term_addr;
   reg  [7:0]  term_char;
   reg  [7:0]  cur_addr;
   reg  [7:0]  shift;
   reg  [7:0]  last_char;
   reg  [2:0]  bit_cnt;
   reg  [1:0]  irq_status;
   reg  [1:0]  irq_mask;
   reg  [2:0]  clk_sync;
   reg  [1:0]  cts_sync;
   reg  [1:0]  dsr_sync;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function sel_match;
      input [7:0] a;
      begin
         sel_match = &(a | ~`SSTC_SELECT_CODE);
      end
   endfunction

   function is_reg;
      input [11:0] a;
      input [11:0] off;
      begin
         is_reg = (a == off);
      end
   endfunction

   // ------------------------------------------------------------
   // apb access: one wait state, effect at the pready edge
   // ------------------------------------------------------------
   wire        access   = psel_i & penable_i & ready;
   wire        wr       = access & pwrite_i;
   wire [7:0]  wbyte    = pwdata_i[7:0];
   wire        buf_hit  = (paddr_i[`SSTC_BUF_PAGE_HI:`SSTC_BUF_PAGE_LO] == `SSTC_BUF_PAGE);
   wire [7:0]  buf_idx  = paddr_i[`SSTC_BUF_IDX_HI:`SSTC_BUF_IDX_LO];
   wire        wr_sel   = wr & is_reg(paddr_i, `SSTC_OFF_SELECT);
   wire        str_ofl  = wr & selected & is_reg(paddr_i, `SSTC_OFF_FLAG_OUT);
   wire        str_tx   = wr & selected & is_reg(paddr_i, `SSTC_OFF_TRANSMIT);
   wire        str_init = wr & selected & is_reg(paddr_i, `SSTC_OFF_INIT);
   wire        str_device_clear_strobe = wr & selected & is_reg(paddr_i, `SSTC_OFF_DEV_CLEAR);

   assign pready_o = ready;

   always @(posedge clock_i) begin
      if (rst_i) begin
         ready <= 1'b0;
      end else begin
         ready <= psel_i & penable_i & ~ready;
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   wire clk_fall = clk_sync[2] & ~clk_sync[1];
   wire cts      = cts_sync[1];
   wire dsr      = dsr_sync[1];

   always @(posedge clock_i) begin
      if (rst_i) begin
         clk_sync <= 3'h0;
         cts_sync <= 2'h0;
         dsr_sync <= 2'h0;
      end else begin
         clk_sync <= {clk_sync[1:0], tx_clk_i};
         cts_sync <= {cts_sync[0], cts_i};
         dsr_sync <= {dsr_sync[0], dsr_i};
      end
   end

   // ------------------------------------------------------------
   // character sequencer
   // ------------------------------------------------------------
   wire        boundary  = clk_fall & (bit_cnt == `SSTC_BIT_LAST);
   wire        at_term   = ~first & (cur_addr == term_addr);
   wire [7:0]  next_addr = first ? cur_addr : cur_addr + 8'h01;
   wire [7:0]  fetch     = buffer_mem[next_addr];
   wire        hit_char  = (fetch == term_char);
   wire        step      = boundary & active & cts;
   wire        end_addr  = step & at_term;
   wire        end_char  = step & ~at_term & hit_char;
   wire        tx_done   = end_addr | end_char;
   wire        stop      = str_init | str_device_clear_strobe | tx_done;

   always @(posedge clock_i) begin
      if (wr & buf_hit) begin
         buffer_mem[buf_idx] <= wbyte;
      end
   end

   always @(posedge clock_i) begin
      if (rst_i) begin
         not_busy  <= 1'b1;
         rts_o     <= 1'b0;
         active    <= 1'b0;
         first     <= 1'b0;
         cur_addr  <= `SSTC_ZERO_BYTE;
         shift     <= `SSTC_SYN_CHAR;
         last_char <= `SSTC_ZERO_BYTE;
         bit_cnt   <= `SSTC_BIT_FIRST;
         txd_o     <= 1'b1;
      end else begin
         if (stop) begin
            not_busy <= 1'b1;
            rts_o    <= 1'b0;
            active   <= 1'b0;
            if (end_char) begin
               cur_addr <= next_addr;
            end
         end else if (str_tx) begin
            not_busy <= 1'b0;
            rts_o    <= 1'b1;
            active   <= 1'b1;
            first    <= 1'b1;
            cur_addr <= start_addr;
         end else if (step) begin
            first    <= 1'b0;
            cur_addr <= next_addr;
         end
         if (clk_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            txd_o   <= shift[bit_cnt];
         end
         if (boundary) begin
            if (step & ~tx_done) begin
               shift     <= fetch;
               last_char <= fetch;
            end else if (active & ~tx_done) begin
               shift <= `SSTC_MARK_CHAR;
            end else begin
               shift <= `SSTC_SYN_CHAR;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // selection, modem flags, addresses
   // ------------------------------------------------------------
   always @(posedge clock_i) begin
      if (rst_i) begin
         selected   <= 1'b0;
         dtr_o      <= 1'b0;
         start_addr <= `SSTC_ZERO_BYTE;
         term_addr  <= `SSTC_ZERO_BYTE;
         term_char  <= `SSTC_ZERO_BYTE;
      end else begin
         if (str_init) begin
            selected <= 1'b0;
         end else if (wr_sel) begin
            selected <= sel_match(wbyte);
         end
         if (str_ofl) begin
            dtr_o <= wbyte[`SSTC_OUT_DTR];
         end
         if (wr & is_reg(paddr_i, `SSTC_OFF_START_ADDR)) begin
            start_addr <= wbyte;
         end
         if (wr & is_reg(paddr_i, `SSTC_OFF_TERM_ADDR)) begin
            term_addr <= wbyte;
         end
         if (wr & is_reg(paddr_i, `SSTC_OFF_TERM_CHAR)) begin
            term_char <= wbyte;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   reg        dsr_prev;
   wire [1:0] irq_event;
   wire       irq_wr  = wr & is_reg(paddr_i, `SSTC_OFF_IRQ_STATUS);
   wire [1:0] irq_clr = irq_wr ? pwdata_i[`SSTC_IRQ_W-1:0] : 2'h0;

   assign irq_event[`SSTC_IRQ_DONE] = stop;
   assign irq_event[`SSTC_IRQ_DSR]  = dsr ^ dsr_prev;
   assign irq_level6_o = not_busy;
   assign irq_o        = |(irq_status & irq_mask);

   always @(posedge clock_i) begin
      if (rst_i) begin
         irq_status <= 2'h0;
         irq_mask   <= 2'h0;
         dsr_prev   <= 1'b0;
      end else begin
         dsr_prev   <= dsr;
         irq_status <= (irq_status & ~irq_clr) | irq_event;
         if (wr & is_reg(paddr_i, `SSTC_OFF_IRQ_MASK)) begin
            irq_mask <= pwdata_i[`SSTC_IRQ_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   reg [7:0] rbyte;
   reg       rmiss;
   reg [7:0] flags_in;

   always @* begin
      flags_in = `SSTC_ZERO_BYTE;
      flags_in[`SSTC_FLAG_NOT_BUSY] = not_busy;
      flags_in[`SSTC_FLAG_DSR]      = dsr;
      rbyte = `SSTC_ZERO_BYTE;
      rmiss = 1'b0;
      if (buf_hit) begin
         rbyte = buffer_mem[buf_idx];
      end else begin
         case (paddr_i)
            `SSTC_OFF_SELECT:     rbyte = {7'h00, selected};
            `SSTC_OFF_FLAG_IN:    rbyte = selected ? flags_in : `SSTC_OPEN_BUS;
            `SSTC_OFF_FLAG_OUT:   rbyte = {3'h0, dtr_o, 4'h0};
            `SSTC_OFF_DATA_IN:    rbyte = selected ? last_char : `SSTC_OPEN_BUS;
            `SSTC_OFF_TRANSMIT:   rbyte = `SSTC_ZERO_BYTE;
            `SSTC_OFF_INIT:       rbyte = `SSTC_ZERO_BYTE;
            `SSTC_OFF_DEV_CLEAR:  rbyte = `SSTC_ZERO_BYTE;
            `SSTC_OFF_START_ADDR: rbyte = start_addr;
            `SSTC_OFF_TERM_ADDR:  rbyte = term_addr;
            `SSTC_OFF_TERM_CHAR:  rbyte = term_char;
            `SSTC_OFF_CUR_ADDR:   rbyte = cur_addr;
            `SSTC_OFF_IRQ_STATUS: rbyte = {6'h00, irq_status};
            `SSTC_OFF_IRQ_MASK:   rbyte = {6'h00, irq_mask};
            default:              rmiss = 1'b1;
         endcase
      end
   end

   always @(posedge clock_i) begin
      if (rst_i) begin
         prdata_o  <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else if (psel_i & penable_i & ~ready) begin
         prdata_o  <= {24'h000000, rbyte};
         pslverr_o <= rmiss;
      end else begin
         pslverr_o <= 1'b0;
      end
   end

endmodule // sstc_controller

//--- test/sstc_checker.sv
/* checker: apb timing, modem flags and transmit relations at the controller ports.
   assumes binding to sstc_controller, one clock domain. */
`timescale 1ns/1ps
module sstc_checker (
   input wire        clock_i,
   input wire        rst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire        pready_o,
   input wire [31:0] prdata_o,
   input wire        pslverr_o,
   input wire        tx_clk_i,
   input wire        cts_i,
   input wire        dsr_i,
   input wire        txd_o,
   input wire        rts_o,
   input wire        dtr_o,
   input wire        irq_level6_o,
   input wire        irq_o
);
   logic       sel;
   logic [9:0] mark_cnt;
   wire        wr_done = psel_i & penable_i & pready_o & pwrite_i;
   wire        rd_done = psel_i & penable_i & pready_o & ~pwrite_i;
   // shadow of selection and cycles spent busy without clear to send
   always @(posedge clock_i) begin
      if (rst_i || (wr_done && sel && paddr_i == 12'h014))
         sel <= 1'b0;
      else if (wr_done && paddr_i == 12'h000)
         sel <= (pwdata_i[7:0] & 8'hc3) == 8'hc3;
      if (rst_i || irq_level6_o || cts_i)
         mark_cnt <= 10'h000;
      else if (mark_cnt != 10'h3ff)
         mark_cnt <= mark_cnt + 10'h001;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_pready_one_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
      else $error("pready not one cycle after access start");
   a_irq6_not_busy: assert property (irq_level6_o != rts_o)
      else $error("level 6 interrupt disagrees with busy state");
   a_irq6_flag: assert property (rd_done && sel && paddr_i == 12'h004
      |-> prdata_o[7] == $past(irq_level6_o))
      else $error("level 6 interrupt disagrees with not busy flag");
   a_dtr_from_write: assert property (wr_done && sel && paddr_i == 12'h008
      |=> dtr_o == $past(pwdata_i[4]))
      else $error("dtr not taken from bit 4");
   a_dtr_unselected: assert property (wr_done && !sel && paddr_i == 12'h008
      |=> $stable(dtr_o))
      else $error("dtr changed while unselected");
   a_open_bus: assert property (rd_done && !sel
      && (paddr_i == 12'h004 || paddr_i == 12'h00c) |-> prdata_o == 32'h000000ff)
      else $error("unselected read not open bus");
   a_dsr_live: assert property (($stable(dsr_i) [*8]) ##0
      (rd_done && sel && paddr_i == 12'h004) |-> prdata_o[1] == dsr_i)
      else $error("dsr flag wrong");
   a_transmit_start: assert property (wr_done && sel && paddr_i == 12'h010
      && irq_level6_o |=> rts_o && !irq_level6_o)
      else $error("transmit did not raise rts");
   a_strobe_stops: assert property (wr_done && sel
      && (paddr_i == 12'h014 || paddr_i == 12'h018) |=> (!rts_o && irq_level6_o) [*2])
      else $error("init or clear did not stop");
   a_marks_no_cts: assert property (mark_cnt >= 10'h258 |-> txd_o)
      else $error("data sent without clear to send");
   c_transmit: cover property (wr_done && sel && paddr_i == 12'h010);
   c_done: cover property ($rose(irq_level6_o));
   c_marks: cover property (mark_cnt == 10'h258);
endmodule // sstc_checker
bind sstc_controller sstc_checker u_chk (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .tx_clk_i(tx_clk_i),
   .cts_i(cts_i), .dsr_i(dsr_i), .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o),
   .irq_level6_o(irq_level6_o), .irq_o(irq_o));

//--- test/sstc_modem.sv
/* modem model: free transmit clock, clear to send after request, receive shift.
   assumes data bits change on the falling transmit clock, lsb first. */
`timescale 1ns/1ps
module sstc_modem (
   input  wire        rts_i,
   input  wire        txd_i,
   input  wire        hold_i,
   output logic       tx_clk_o,
   output logic       cts_o,
   output logic [7:0] rx_shift_o
);
   initial begin
      tx_clk_o = 1'b0;
      cts_o = 1'b0;
      rx_shift_o = 8'h00;
   end
   always #80 tx_clk_o = ~tx_clk_o;
   // hold keeps clear to send low, for stalled transmit
   always @(posedge tx_clk_o) begin
      cts_o <= rts_i & ~hold_i;
      rx_shift_o <= {txd_i, rx_shift_o[7:1]};
   end
endmodule // sstc_modem

//--- test/tb_top.sv
/* bench: apb scenarios for the controller against the modem model.
   assumes the checker binds itself to the controller. */
`timescale 1ns/1ps
module tb_top;
   logic        clock_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, dsr = 0, hold = 1;
   logic [11:0] padr = 0;
   logic [31:0] pwd = 0, prd, q;
   logic        prdy, perr, err, txd, rts, dtr, irq6, irq, tclk, cts, found;
   logic [7:0]  rxs;
   logic [7:0]  sel3 [4] = '{8'h43, 8'h83, 8'hc1, 8'hc2};
   logic [7:0]  tch [4] = '{8'h00, 8'hff, 8'h16, 8'h5a};
   int          bad_count = 0, samples_checked = 0, n, i;
   always #2.5 clock_i = ~clock_i;
   sstc_controller u_dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .pready_o(prdy), .prdata_o(prd),
      .pslverr_o(perr), .tx_clk_i(tclk), .cts_i(cts), .dsr_i(dsr), .txd_o(txd),
      .rts_o(rts), .dtr_o(dtr), .irq_level6_o(irq6), .irq_o(irq));
   sstc_modem u_modem (.rts_i(rts), .txd_i(txd), .hold_i(hold), .tx_clk_o(tclk),
      .cts_o(cts), .rx_shift_o(rxs));
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clock_i);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock_i);
      {psel, pwr, padr, pwd} <= {1'b1, w, a, d};
      @(posedge clock_i);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (prdy !== 1'b1 && k < 20);
      q = prd;
      err = perr;
      {psel, pen} <= 2'b00;
      if (k >= 20) begin
         bad_count++;
         end_sim;
      end
   endtask
   task xmit(input logic [7:0] s, t, c);
      apb(1, 12'h01c, s);
      apb(1, 12'h020, t);
      apb(1, 12'h024, c);
      apb(1, 12'h010, 0);
      cyc(2);
   endtask
   task waitdone;
      n = 0;
      while (irq6 !== 1'b1 && n < 20000) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 20000) begin
         bad_count++;
         end_sim;
      end
   endtask
   initial begin
      cyc(20);
      rst_i <= 1'b0;
      for (i = 0; i < 4; i++) begin
         apb(1, 12'h000, sel3[i]);
         apb(0, 12'h004, 0);
         chk(q, 32'hff);
         apb(0, 12'h00c, 0);
         chk(q, 32'hff);
      end
      apb(1, 12'h000, 32'hc3);
      apb(0, 12'h004, 0);
      chk(q & 32'h82, 32'h80);
      apb(1, 12'h008, 32'h10);
      cyc(1);
      chk(dtr, 1);
      apb(1, 12'h008, 32'hef);
      cyc(1);
      chk(dtr, 0);
      dsr <= 1'b1;
      cyc(10);
      apb(0, 12'h004, 0);
      chk(q[1], 1);
      apb(0, 12'h034, 0);
      chk(err, 1);
      chk(q, 0);
      cyc(600);
      found = 0;
      repeat (24) begin
         @(negedge tclk);
         found |= (rxs === 8'h16);
      end
      chk(found, 1);
      for (i = 0; i < 4; i++)
         apb(1, 12'(12'h408 + 4 * i), 32'(8'ha5 ^ i));
      xmit(2, 5, 0);
      chk({rts, irq6}, 2'b10);
      apb(0, 12'h004, 0);
      chk(q[7], 0);
      cyc(800);
      chk(rxs, 8'hff);
      apb(0, 12'h028, 0);
      chk(q, 2);
      hold <= 1'b0;
      waitdone;
      chk(n >= 1024, 1);
      apb(0, 12'h028, 0);
      chk(q, 5);
      chk({rts, irq6}, 2'b01);
      apb(0, 12'h00c, 0);
      chk(q, 32'ha6);
      apb(0, 12'h02c, 0);
      chk(q[1], 1);
      for (i = 0; i < 4; i++) begin
         apb(1, 12'h428, ~tch[i]);
         apb(1, 12'h42c, tch[i]);
         apb(1, 12'h430, ~tch[i]);
         xmit(10, 12, tch[i]);
         found = 0;
         repeat (24) begin
            @(negedge tclk);
            found |= (rxs === ~tch[i]);
         end
         chk(found, 1);
         waitdone;
         apb(0, 12'h028, 0);
         chk(q, 11);
      end
      chk(irq, 0);
      apb(1, 12'h030, 1);
      cyc(1);
      chk(irq, 1);
      apb(1, 12'h02c, 1);
      cyc(1);
      chk(irq, 0);
      hold <= 1'b1;
      xmit(2, 5, 0);
      apb(1, 12'h018, 0);
      cyc(1);
      chk({rts, irq6, irq}, 3'b011);
      xmit(2, 5, 0);
      apb(1, 12'h014, 0);
      cyc(1);
      chk({rts, irq6}, 2'b01);
      apb(0, 12'h004, 0);
      chk(q, 32'hff);
      apb(1, 12'h010, 0);
      apb(1, 12'h008, 32'h10);
      cyc(1);
      chk({rts, dtr}, 2'b00);
      end_sim;
   end
endmodule // tb_top
